// [design/dac_serial_write_port.sv]
// Purpose: three-wire serial write port feeding the dac register and power mode
// Assumes: i_clk is several times faster than the serial clock; pins are asynchronous
// Notes:   serial clock edges are found by oversampling, not used as a clock
`timescale 1ns/10ps

// How it works
// - frame sync low enables shifting
// - shift one bit per serial clock fall
// - sixteen bit shift register per frame
// - apply word at sixteenth fall, sync low
// - early sync rise discards partial word
// - first two bits set power mode
// - next twelve bits code, last two ignored
module dac_serial_write_port
#(
  parameter int WORD_BITS = dac_port_pkg::WORD_BITS
)
(
  // clock and reset
  input  wire logic                                  i_clk,
  input  wire logic                                  i_reset,
  // serial pins from the host
  input  wire logic                                  i_frame_sync_n,
  input  wire logic                                  i_serial_clk,
  input  wire logic                                  i_serial_data_in,
  // applied setting
  output dac_port_pkg::dac_setting_type              o_setting,
  output logic                                       o_update,
  output logic                                       o_abort,
  output logic                                       o_frame_active
);

  localparam int STAGES = dac_port_pkg::SYNC_STAGES;

  // pin order inside the resynchroniser vector and the level each pin idles at
  localparam int              PINS     = 3;
  localparam int              PIN_DATA = 0;
  localparam int              PIN_SCLK = 1;
  localparam int              PIN_SYNC = 2;
  localparam logic [PINS-1:0] PIN_IDLE = 3'h4;

  // idle: waiting for sync fall; shift: taking bits; held: word applied, waiting for sync rise
  typedef enum logic [2:0]
  {
    FRAME_IDLE  = 3'h1,
    FRAME_SHIFT = 3'h2,
    FRAME_HELD  = 3'h4
  } frame_state_type;

  logic [PINS-1:0]                     pin_raw;
  logic [PINS-1:0]                     pin_level;
  frame_state_type                     frame_state;
  logic                                last_fall;
  logic                                sync_n;
  logic                                sclk;
  logic                                serial_data_in;
  logic                                sync_n_prev;
  logic                                sclk_prev;
  logic                                sync_fall;
  logic                                sync_rise;
  logic                                sclk_fall;
  logic [WORD_BITS-1:0]                shift;
  logic [WORD_BITS-1:0]                next_shift;
  logic [dac_port_pkg::COUNT_BITS-1:0] count;
  logic                                done;

  assign pin_raw[PIN_DATA] = i_serial_data_in;
  assign pin_raw[PIN_SCLK] = i_serial_clk;
  assign pin_raw[PIN_SYNC] = i_frame_sync_n;

  // three-stage resynchroniser per pin; a level is taken once stages two and three agree
  for (genvar p = 0; p < PINS; p++)
  begin : g_pin_sync
    logic [STAGES-1:0] pipe;

    always_ff @(posedge i_clk)
    begin
      if (i_reset)
        pipe <= {STAGES{PIN_IDLE[p]}};
      else
        pipe <= {pipe[STAGES-2:0], pin_raw[p]};
    end

    // glitches shorter than two cycles never reach the filtered level
    always_ff @(posedge i_clk)
    begin
      if (i_reset)
        pin_level[p] <= PIN_IDLE[p];
      else if (pipe[1] == pipe[2])
        pin_level[p] <= pipe[2];
    end
  end

  assign sync_n = pin_level[PIN_SYNC];
  assign sclk   = pin_level[PIN_SCLK];
  assign serial_data_in   = pin_level[PIN_DATA];

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sync_n_prev <= 1'b1;
      sclk_prev   <= 1'b0;
    end
    else
    begin
      sync_n_prev <= sync_n;
      sclk_prev   <= sclk;
    end
  end

  assign sync_fall = sync_n_prev & ~sync_n;
  assign sync_rise = ~sync_n_prev & sync_n;
  assign sclk_fall = sclk_prev & ~sclk;
  assign done      = (count == dac_port_pkg::COUNT_FULL);

  // shifting enabled only while frame sync is low and word not yet full
  assign next_shift = {shift[WORD_BITS-2:0], serial_data_in};

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      shift <= '0;
      count <= dac_port_pkg::COUNT_ZERO;
    end
    else if (sync_fall)
    begin
      count <= dac_port_pkg::COUNT_ZERO;
      shift <= '0;
    end
    else if (!sync_n && !done && sclk_fall)
    begin
      shift <= next_shift;
      count <= count + dac_port_pkg::COUNT_ONE;
    end
    else if (sync_rise && !done)
      count <= dac_port_pkg::COUNT_ZERO;
  end

  // the serial clock fall that completes the word
  assign last_fall = sclk_fall && (count == dac_port_pkg::COUNT_FULL - dac_port_pkg::COUNT_ONE);

  // a frame left low after completion parks in held until sync rises, then returns to idle
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      frame_state <= FRAME_IDLE;
    else
    begin
      unique case (frame_state)
        FRAME_IDLE:
        begin
          if (sync_fall)
            frame_state <= FRAME_SHIFT;
        end
        FRAME_SHIFT:
        begin
          if (sync_fall)
            frame_state <= FRAME_SHIFT;
          else if (sync_n)
            frame_state <= FRAME_IDLE;
          else if (last_fall)
            frame_state <= FRAME_HELD;
        end
        FRAME_HELD:
        begin
          if (sync_fall)
            frame_state <= FRAME_SHIFT;
          else if (sync_n)
            frame_state <= FRAME_IDLE;
        end
      endcase
    end
  end

  // a state bit, so the output still comes straight from a flip-flop
  assign o_frame_active = frame_state[1];

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_setting.mode <= dac_port_pkg::MODE_NORMAL;
      o_setting.code <= dac_port_pkg::CODE_RESET;
      o_update       <= 1'b0;
    end
    else if (!sync_n && !sync_fall && !done && sclk_fall
             && count == dac_port_pkg::COUNT_FULL - dac_port_pkg::COUNT_ONE)
    begin
      o_setting.mode <= dac_port_pkg::power_mode_type'(
                          next_shift[dac_port_pkg::MODE_MSB:dac_port_pkg::MODE_LSB]);
      o_setting.code <= next_shift[dac_port_pkg::CODE_MSB:dac_port_pkg::CODE_LSB];
      o_update       <= 1'b1;
    end
    else
      o_update <= 1'b0;
  end

  // pulse when a partial word is thrown away; setting is left untouched
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_abort <= 1'b0;
    else
      o_abort <= sync_rise && !done && (count != dac_port_pkg::COUNT_ZERO);
  end

endmodule : dac_serial_write_port

// [include/dac_port_pkg.sv]
// Purpose: shared constants and types for the dac serial write port
// Assumes: word is sent most significant bit first
// Notes:   pin inputs are resynchronised to i_clk inside the port
package dac_port_pkg;

  localparam int WORD_BITS    = 16;
  localparam int COUNT_BITS   = 5;
  localparam int MODE_BITS    = 2;
  localparam int CODE_BITS    = 12;
  localparam int SYNC_STAGES  = 3;

  // field positions inside the received word, first bit in is bit 15
  localparam int MODE_MSB     = 15;
  localparam int MODE_LSB     = 14;
  localparam int CODE_MSB     = 13;
  localparam int CODE_LSB     = 2;

  localparam logic [COUNT_BITS-1:0] COUNT_ZERO = 5'h00;
  localparam logic [COUNT_BITS-1:0] COUNT_ONE  = 5'h01;
  localparam logic [COUNT_BITS-1:0] COUNT_FULL = 5'h10;

  typedef enum logic [1:0]
  {
    MODE_NORMAL   = 2'h0,
    MODE_PD_1K    = 2'h1,
    MODE_PD_100K  = 2'h2,
    MODE_PD_OPEN  = 2'h3
  } power_mode_type;

  localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;

  // applied setting that drives the converter
  typedef struct packed
  {
    power_mode_type          mode;
    logic [CODE_BITS-1:0]    code;
  } dac_setting_type;

endpackage : dac_port_pkg

// [verif/dac_host_model.sv]
// Purpose: serial master that writes words to the port
// Assumes: serial clock idles low, 8 cycle period
// Notes:   released data line shows the inverse of its last bit
`timescale 1ns/10ps
module dac_host_model
(
  // pins
  input  wire logic i_clk,
  output logic      o_frame_sync_n = 1'b1,
  output logic      o_serial_clk = 1'b0,
  output logic      o_serial_data_in = 1'b0
);
  task automatic write(input logic [15:0] word, input int nbits);
    o_frame_sync_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (int i = 0; i < nbits; i++)
    begin
      o_serial_data_in <= word[15 - (i % 16)];
      o_serial_clk     <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_serial_clk <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
    o_frame_sync_n   <= 1'b1;
    o_serial_data_in <= ~o_serial_data_in;
    repeat (8) @(posedge i_clk);
  endtask : write
endmodule : dac_host_model

// [verif/dac_port_checker.sv]
// Purpose: port checks for the dac serial write port
// Assumes: pins come from a well-behaved host
// Notes:   bound to the design top
`timescale 1ns/10ps
module dac_port_checker
#(
  parameter int WORD_BITS = 16
)
(
  // clock, reset and pins
  input wire logic                          i_clk,
  input wire logic                          i_reset,
  input wire logic                          i_frame_sync_n,
  input wire logic                          i_serial_clk,
  input wire logic                          i_serial_data_in,
  // results
  input wire dac_port_pkg::dac_setting_type o_setting,
  input wire logic                          o_update,
  input wire logic                          o_abort,
  input wire logic                          o_frame_active
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence sync_idle; i_frame_sync_n [*8]; endsequence
  sequence frame_open; $fell(i_frame_sync_n) ##0 !i_frame_sync_n [*8]; endsequence
  sequence sync_held; !i_frame_sync_n [*8]; endsequence
  idle_quiet_a: assert property (sync_idle |-> !o_frame_active && !o_update && !o_abort) else $error("idle");
  frame_open_a: assert property (frame_open |-> o_frame_active) else $error("no frame");
  update_pulse_a: assert property (o_update |=> !o_update) else $error("update long");
  abort_pulse_a: assert property (o_abort |=> !o_abort) else $error("abort long");
  update_alone_a: assert property (o_update |-> !o_abort && !o_frame_active) else $error("update");
  abort_close_a: assert property (o_abort |=> !o_frame_active) else $error("abort");
  setting_hold_a: assert property (!o_update |-> $stable(o_setting)) else $error("setting moved");
  extra_ignored_a: assert property (sync_held ##0 o_update ##1 sync_held |-> !o_frame_active) else $error("x");
endmodule : dac_port_checker
bind dac_serial_write_port dac_port_checker #(.WORD_BITS(WORD_BITS)) chk (.*);

// [verif/tb.sv]
// Purpose: self-checking bench for the dac serial write port
// Assumes: host model drives the pins
// Notes:   pulses are counted by monitors
`timescale 1ns/10ps
module tb;
  logic                          i_clk = 1'b0;
  logic                          i_reset = 1'b1;
  logic                          i_frame_sync_n;
  logic                          i_serial_clk;
  logic                          i_serial_data_in;
  dac_port_pkg::dac_setting_type o_setting;
  logic                          o_update;
  logic                          o_abort;
  logic                          o_frame_active;
  int                            error_cnt = 0;
  int                            checks = 0;
  int                            upd_cnt = 0;
  int                            abt_cnt = 0;
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_update === 1'b1) upd_cnt++;
  always @(posedge i_clk) if (o_abort === 1'b1) abt_cnt++;
  dac_host_model host (.i_clk, .o_frame_sync_n(i_frame_sync_n), .o_serial_clk(i_serial_clk),
                       .o_serial_data_in(i_serial_data_in));
  dac_serial_write_port uut (.*);
  task automatic check(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : check
  task automatic run(input logic [15:0] w, input int n, input int upd, input int abt, input logic [13:0] exp);
    upd_cnt = 0;
    abt_cnt = 0;
    host.write(w, n);
    check(o_setting === exp && upd_cnt == upd && abt_cnt == abt, "bad result");
  endtask : run
  task automatic finish_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (6) @(posedge i_clk);
    check(o_setting === 14'h0000 && o_frame_active === 1'b0, "reset state");
    for (int m = 0; m < 4; m++)
      run({m[1:0], 12'hE9D, ~m[1:0]}, 16, 1, 0, {m[1:0], 12'hE9D});
    $display("modes done");
    run(16'h0FFF, 9, 0, 1, 14'h3E9D);
    $display("abort done");
    run(16'h8123, 20, 1, 0, 14'h2048);
    $display("extra clocks done");
    finish_test();
  end
  initial
  begin
    #1000000;
    error_cnt++;
    finish_test();
  end
endmodule : tb
